// ==== rtl/fsp_pkg.sv ====
`default_nettype none
package fsp_pkg;
  // Status bit positions
  localparam int BIT_BUSY = 0;
  localparam int BIT_LATCH = 1;
  localparam int BIT_BP_LO = 2;
  localparam int BIT_BP_HI = 6;
  localparam int BIT_GUARD_LO = 7;
  localparam int BIT_GUARD_HI = 8;
  localparam int BIT_QUAD = 9;
  localparam int BIT_LOCK = 10;
  localparam int BIT_PERF = 13;
  localparam int BIT_INVERT = 14;
  localparam int BIT_SUS = 15;
  // Bits kept in the non-volatile store
  localparam logic [15:0] NV_MASK = 16'h47fc;
  // Value of the non-volatile word after a factory clear
  localparam logic [15:0] NV_DEFAULT = 16'h0000;
  // Command codes
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_QUAD_PROGRAM = 8'h32;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE32 = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE64 = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
  localparam logic [7:0] OP_QUAD_WORD_READ = 8'he7;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  // Status write cell time; the figure is a plain default
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SRW_TIME_NS = 1000;
  localparam int SRW_CYCLES_INT = (SRW_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] SRW_CYCLES = 8'(SRW_CYCLES_INT);
  localparam logic [7:0] TIMER_RESET = 8'h00;
endpackage : fsp_pkg
`default_nettype wire

// ==== rtl/fsp_nv_store.sv ====
`timescale 1ns/10ps
`default_nettype none
module fsp_nv_store (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data_ff
);
  import fsp_pkg::*;
  // Cells carry no reset: they keep their word across a power cycle
  logic [15:0] cell_ff;
  logic [15:0] nxt_cell;
  logic [15:0] nxt_rd_data;

  // Write port and registered read
  always_comb begin
    nxt_cell = wr_en ? (wr_data & NV_MASK) : cell_ff;
    nxt_rd_data = rstn ? cell_ff : 16'h0000;
  end

  always_ff @(posedge sys_clk) begin
    cell_ff <= nxt_cell;
    rd_data_ff <= nxt_rd_data;
  end
endmodule : fsp_nv_store
`default_nettype wire

// ==== rtl/fsp_status_reg.sv ====
// Overview of operation
// - Busy flag high during program, erase, status write
// - Latch clear rejects status write, program, erase
// - Block guards non-volatile, set only by status write
// - Block guards change only outside hardware protection
// - Chip erase needs guards 000/invert0 or 111/invert1
// - Guard mode 00: writes allowed with latch set
// - Guard mode 01, protect pin low: writes refused
// - Guard mode 01, protect pin high: writes allowed
// - Guard mode 10 locks until power cycle, then 00
// - Guard mode 11 locks status writes until a factory clear
// - Quad enable non-volatile, default 0, repurposes pins
// - Security lock bit 10 sets once, cleared only by factory clear
// - Guard invert bit 14 non-volatile, default 0
// - High performance flag read-only, follows mode
// - Suspend flag bit 15 set by suspend
// - Suspend flag cleared by resume, reset, power
// - Latch set by enable, cleared by listed events
// - Quad commands honoured only with quad enable
`timescale 1ns/10ps
`default_nettype none
module fsp_status_reg (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_opcode,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_two_bytes,
  input wire logic protect_pin,
  input wire logic engine_busy,
  input wire logic high_perf_mode,
  input wire logic nv_factory_init,
  output logic [15:0] status_rdata_ff,
  output logic program_busy_flag_ff,
  output logic write_latch_flag_ff,
  output logic quad_lane_enable_ff,
  output logic security_lock_bit_ff,
  output logic [4:0] block_guard_bits_ff,
  output logic guard_invert_ff,
  output logic engine_start_ff,
  output logic [7:0] engine_opcode_ff,
  output logic suspend_req_ff,
  output logic resume_req_ff,
  output logic quad_read_go_ff,
  output logic cmd_reject_ff
);
  import fsp_pkg::*;

  typedef enum logic [1:0] {ST_FETCH, ST_LOAD, ST_IDLE, ST_SRW} fsp_state_type;

  // Lock decode of the guard mode bits and pin: 1 when writes are locked
  function automatic logic sr_locked(input logic [1:0] srp, input logic pin);
    case (srp)
      2'b00: sr_locked = 1'b0;
      2'b01: sr_locked = !pin;
      default: sr_locked = 1'b1;
    endcase
  endfunction : sr_locked

  // Merge written data into the non-volatile word
  function automatic logic [15:0] merge_nv(input logic [15:0] old, input logic [15:0] d,
                                           input logic two);
    logic [15:0] res;
    res = old;
    res[BIT_BP_HI:BIT_BP_LO] = d[BIT_BP_HI:BIT_BP_LO];
    res[BIT_GUARD_LO] = d[BIT_GUARD_LO];
    if (two) begin
      res[BIT_GUARD_HI] = d[BIT_GUARD_HI];
      res[BIT_QUAD] = d[BIT_QUAD];
      res[BIT_LOCK] = old[BIT_LOCK] | d[BIT_LOCK];
      res[BIT_INVERT] = d[BIT_INVERT];
    end
    merge_nv = res & NV_MASK;
  endfunction : merge_nv

  // Protect pin crosses in through two flops
  logic pin_meta_ff;
  logic pin_sync_ff;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
    end else begin
      pin_meta_ff <= protect_pin;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  fsp_state_type state_ff, nxt_state;
  logic [7:0] timer_ff, nxt_timer;
  logic [15:0] nv_ff, nxt_nv;
  logic [15:0] pend_ff, nxt_pend;
  logic latch_ff, nxt_latch;
  logic sus_ff, nxt_sus;
  logic arm_ff, nxt_arm;
  logic start_ff, nxt_start;
  logic [7:0] op_ff, nxt_op;
  logic susp_ff, nxt_susp;
  logic resm_ff, nxt_resm;
  logic qgo_ff, nxt_qgo;
  logic rej_ff, nxt_rej;
  logic nv_wr_en;
  logic [15:0] nv_wr_data;
  logic [15:0] nv_rd_data;
  logic pin_eff;
  logic busy_now;
  logic is_write_op;
  logic is_quad_op;
  logic ce_ok;

  fsp_nv_store u_nv (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .wr_en(nv_wr_en),
    .wr_data(nv_wr_data),
    .rd_data_ff(nv_rd_data)
  );

  // With quad lanes on, the protect pin is a data lane and loses its guard role
  assign pin_eff = nv_ff[BIT_QUAD] ? 1'b1 : pin_sync_ff;
  assign busy_now = engine_busy | (state_ff == ST_SRW);
  assign is_quad_op = (cmd_opcode == OP_QUAD_OUT_READ) || (cmd_opcode == OP_QUAD_IO_READ) ||
                      (cmd_opcode == OP_QUAD_WORD_READ) || (cmd_opcode == OP_QUAD_PROGRAM);
  assign is_write_op = (cmd_opcode == OP_STATUS_WRITE) || (cmd_opcode == OP_PAGE_PROGRAM) ||
                       (cmd_opcode == OP_QUAD_PROGRAM) || (cmd_opcode == OP_SECTOR_ERASE) ||
                       (cmd_opcode == OP_BLOCK_ERASE32) || (cmd_opcode == OP_BLOCK_ERASE64) ||
                       (cmd_opcode == OP_CHIP_ERASE_A) || (cmd_opcode == OP_CHIP_ERASE_B);
  assign ce_ok = ((nv_ff[BIT_BP_LO+2:BIT_BP_LO] == 3'b000) && !nv_ff[BIT_INVERT]) ||
                 ((nv_ff[BIT_BP_LO+2:BIT_BP_LO] == 3'b111) && nv_ff[BIT_INVERT]);

  // Sequencing, command decode and store traffic
  always_comb begin
    nxt_state = state_ff;
    nxt_timer = timer_ff;
    nxt_nv = nv_ff;
    nxt_pend = pend_ff;
    nxt_latch = latch_ff;
    nxt_sus = sus_ff;
    nxt_arm = arm_ff;
    nxt_start = 1'b0;
    nxt_op = op_ff;
    nxt_susp = 1'b0;
    nxt_resm = 1'b0;
    nxt_qgo = 1'b0;
    nxt_rej = 1'b0;
    nv_wr_en = 1'b0;
    nv_wr_data = nv_ff;
    case (state_ff)
      ST_FETCH: nxt_state = ST_LOAD;
      ST_LOAD: begin
        // A power cycle ends the lock-down mode
        nxt_nv = nv_rd_data & NV_MASK;
        if (nv_rd_data[BIT_GUARD_HI:BIT_GUARD_LO] == 2'b10) begin
          nxt_nv[BIT_GUARD_HI:BIT_GUARD_LO] = 2'b00;
          nv_wr_en = 1'b1;
          nv_wr_data = nxt_nv;
        end
        nxt_state = ST_IDLE;
      end
      ST_SRW: begin
        // Cells commit at the end of the write time
        if (timer_ff <= 8'h01) begin
          nxt_nv = pend_ff;
          nv_wr_en = 1'b1;
          nv_wr_data = pend_ff;
          nxt_state = ST_IDLE;
          nxt_timer = TIMER_RESET;
        end else begin
          nxt_timer = timer_ff - 8'h01;
        end
      end
      ST_IDLE: begin
        if (nv_factory_init) begin
          nxt_nv = NV_DEFAULT;
          nv_wr_en = 1'b1;
          nv_wr_data = NV_DEFAULT;
        end
      end
      default: nxt_state = ST_FETCH;
    endcase
    // Commands are taken once the store has been loaded
    if (cmd_strobe && (state_ff == ST_IDLE || state_ff == ST_SRW)) begin
      nxt_arm = (cmd_opcode == OP_RESET_ENABLE);
      if (is_quad_op && !nv_ff[BIT_QUAD]) begin
        nxt_rej = 1'b1;
      end else if (is_write_op && (!latch_ff || busy_now)) begin
        nxt_rej = 1'b1;
      end else begin
        case (cmd_opcode)
          OP_LATCH_SET: nxt_latch = 1'b1;
          OP_LATCH_CLEAR: nxt_latch = 1'b0;
          OP_RESET: begin
            if (arm_ff) begin
              nxt_latch = 1'b0;
              nxt_sus = 1'b0;
            end
          end
          OP_STATUS_WRITE: begin
            if (sr_locked(nv_ff[BIT_GUARD_HI:BIT_GUARD_LO], pin_eff)) begin
              nxt_rej = 1'b1;
            end else begin
              nxt_latch = 1'b0;
              nxt_pend = merge_nv(nv_ff, cmd_wdata, cmd_two_bytes);
              nxt_state = ST_SRW;
              nxt_timer = SRW_CYCLES;
            end
          end
          OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
            if (ce_ok) begin
              nxt_latch = 1'b0;
              nxt_start = 1'b1;
              nxt_op = cmd_opcode;
            end else begin
              nxt_rej = 1'b1;
            end
          end
          OP_PAGE_PROGRAM, OP_QUAD_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE32,
          OP_BLOCK_ERASE64: begin
            nxt_latch = 1'b0;
            nxt_start = 1'b1;
            nxt_op = cmd_opcode;
          end
          OP_QUAD_OUT_READ, OP_QUAD_IO_READ, OP_QUAD_WORD_READ: nxt_qgo = 1'b1;
          OP_SUSPEND: begin
            if (engine_busy && !sus_ff) begin
              nxt_sus = 1'b1;
              nxt_susp = 1'b1;
            end
          end
          OP_RESUME: begin
            if (sus_ff) begin
              nxt_sus = 1'b0;
              nxt_resm = 1'b1;
            end
          end
          default: nxt_rej = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_ff <= ST_FETCH;
      timer_ff <= TIMER_RESET;
      nv_ff <= NV_DEFAULT;
      pend_ff <= NV_DEFAULT;
      latch_ff <= 1'b0;
      sus_ff <= 1'b0;
      arm_ff <= 1'b0;
      start_ff <= 1'b0;
      op_ff <= 8'h00;
      susp_ff <= 1'b0;
      resm_ff <= 1'b0;
      qgo_ff <= 1'b0;
      rej_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      nv_ff <= nxt_nv;
      pend_ff <= nxt_pend;
      latch_ff <= nxt_latch;
      sus_ff <= nxt_sus;
      arm_ff <= nxt_arm;
      start_ff <= nxt_start;
      op_ff <= nxt_op;
      susp_ff <= nxt_susp;
      resm_ff <= nxt_resm;
      qgo_ff <= nxt_qgo;
      rej_ff <= nxt_rej;
    end
  end

  // Read image and output registers
  logic [15:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 16'h0000;
    nxt_rdata[BIT_BUSY] = busy_now;
    nxt_rdata[BIT_LATCH] = latch_ff;
    nxt_rdata[BIT_BP_HI:BIT_BP_LO] = nv_ff[BIT_BP_HI:BIT_BP_LO];
    nxt_rdata[BIT_GUARD_LO] = nv_ff[BIT_GUARD_LO];
    nxt_rdata[BIT_GUARD_HI] = nv_ff[BIT_GUARD_HI];
    nxt_rdata[BIT_QUAD] = nv_ff[BIT_QUAD];
    nxt_rdata[BIT_LOCK] = nv_ff[BIT_LOCK];
    nxt_rdata[BIT_PERF] = high_perf_mode;
    nxt_rdata[BIT_INVERT] = nv_ff[BIT_INVERT];
    nxt_rdata[BIT_SUS] = sus_ff;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      status_rdata_ff <= 16'h0000;
      program_busy_flag_ff <= 1'b0;
      write_latch_flag_ff <= 1'b0;
      quad_lane_enable_ff <= 1'b0;
      security_lock_bit_ff <= 1'b0;
      block_guard_bits_ff <= 5'h00;
      guard_invert_ff <= 1'b0;
    end else begin
      status_rdata_ff <= nxt_rdata;
      program_busy_flag_ff <= busy_now;
      write_latch_flag_ff <= latch_ff;
      quad_lane_enable_ff <= nv_ff[BIT_QUAD];
      security_lock_bit_ff <= nv_ff[BIT_LOCK];
      block_guard_bits_ff <= nv_ff[BIT_BP_HI:BIT_BP_LO];
      guard_invert_ff <= nv_ff[BIT_INVERT];
    end
  end

  assign engine_start_ff = start_ff;
  assign engine_opcode_ff = op_ff;
  assign suspend_req_ff = susp_ff;
  assign resume_req_ff = resm_ff;
  assign quad_read_go_ff = qgo_ff;
  assign cmd_reject_ff = rej_ff;

  // Checks next to the logic they guard
  property p_busy_map;
    @(posedge sys_clk) disable iff (!rstn) 1'b1 |=> (status_rdata_ff[BIT_BUSY] == $past(busy_now));
  endproperty
  a_busy_map: assert property (p_busy_map) else $error("busy bit wrong");
  property p_no_latch_reject;
    @(posedge sys_clk) disable iff (!rstn)
      (cmd_strobe && state_ff == ST_IDLE && is_write_op && !latch_ff) |=> (rej_ff && !start_ff);
  endproperty
  a_no_latch_reject: assert property (p_no_latch_reject) else $error("write without latch");
  property p_bp_stable;
    @(posedge sys_clk) disable iff (!rstn)
      (state_ff == ST_IDLE && !nv_factory_init) |=> $stable(nv_ff[BIT_BP_HI:BIT_BP_LO]);
  endproperty
  a_bp_stable: assert property (p_bp_stable) else $error("guards moved outside a write");
  property p_ce_guard;
    @(posedge sys_clk) disable iff (!rstn)
      (start_ff && (op_ff == OP_CHIP_ERASE_A || op_ff == OP_CHIP_ERASE_B)) |-> $past(ce_ok);
  endproperty
  a_ce_guard: assert property (p_ce_guard) else $error("chip erase under guard");
  property p_hw_lock;
    @(posedge sys_clk) disable iff (!rstn)
      (cmd_strobe && state_ff == ST_IDLE && cmd_opcode == OP_STATUS_WRITE &&
       sr_locked(nv_ff[BIT_GUARD_HI:BIT_GUARD_LO], pin_eff)) |=> (state_ff != ST_SRW);
  endproperty
  a_hw_lock: assert property (p_hw_lock) else $error("locked status written");
  property p_srw_len;
    @(posedge sys_clk) disable iff (!rstn)
      $rose(state_ff == ST_SRW) |-> (state_ff == ST_SRW) [*8];
  endproperty
  a_srw_len: assert property (p_srw_len) else $error("status write too short");
  property p_lock_sticky;
    @(posedge sys_clk) disable iff (!rstn)
      (nv_ff[BIT_LOCK] && !nv_factory_init && state_ff != ST_LOAD) |=> nv_ff[BIT_LOCK];
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("security lock cleared");
  property p_sus_set;
    @(posedge sys_clk) disable iff (!rstn)
      (cmd_strobe && state_ff == ST_IDLE && cmd_opcode == OP_SUSPEND && engine_busy && !sus_ff)
      |=> ##1 status_rdata_ff[BIT_SUS];
  endproperty
  a_sus_set: assert property (p_sus_set) else $error("suspend flag not set");
  property p_wel_set;
    @(posedge sys_clk) disable iff (!rstn)
      (cmd_strobe && state_ff == ST_IDLE && cmd_opcode == OP_LATCH_SET) |=> ##1 write_latch_flag_ff;
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch not set");
  property p_reserved;
    @(posedge sys_clk) disable iff (!rstn) status_rdata_ff[12:11] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");
  property p_quad_gate;
    @(posedge sys_clk) disable iff (!rstn) qgo_ff |-> $past(nv_ff[BIT_QUAD]);
  endproperty
  a_quad_gate: assert property (p_quad_gate) else $error("quad read without enable");
  c_srw_done: cover property (@(posedge sys_clk) disable iff (!rstn) $fell(state_ff == ST_SRW));
  c_ce_start: cover property (@(posedge sys_clk) disable iff (!rstn)
    start_ff && op_ff == OP_CHIP_ERASE_A);
  c_suspend: cover property (@(posedge sys_clk) disable iff (!rstn) susp_ff ##[1:50] resm_ff);
  c_reject: cover property (@(posedge sys_clk) disable iff (!rstn) rej_ff);
endmodule : fsp_status_reg
`default_nettype wire

// ==== dv/fsp_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Host side: hands one decoded command per call to the status block
module fsp_host_model (
  input wire logic sys_clk,
  output logic cmd_strobe,
  output logic [7:0] cmd_opcode,
  output logic [15:0] cmd_wdata,
  output logic cmd_two_bytes
);
  // Idle values at time zero
  initial begin
    cmd_strobe = 1'b0;
    cmd_opcode = 8'h00;
    cmd_wdata = 16'h0000;
    cmd_two_bytes = 1'b0;
  end

  // One strobe cycle per command, driven on the falling edge.
  // Callers also send a quad command before the quad enable, expecting
  // a reject, and set the quad enable only once the protect pin is high.
  task automatic send(input logic [7:0] op, input logic [15:0] d, input logic two);
    @(negedge sys_clk);
    cmd_strobe = 1'b1;
    cmd_opcode = op;
    cmd_wdata = d;
    cmd_two_bytes = two;
    @(negedge sys_clk);
    cmd_strobe = 1'b0;
    // Released opcode and data show garbage so stale values cannot be reused
    cmd_opcode = ~op;
    cmd_wdata = ~d;
  endtask : send
endmodule : fsp_host_model
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fsp_pkg::*;
  logic sys_clk, rstn, protect_pin, engine_busy, high_perf_mode, nv_factory_init;
  logic cmd_strobe, cmd_two_bytes;
  logic [7:0] cmd_opcode, engine_opcode_ff;
  logic [15:0] cmd_wdata, status_rdata_ff;
  logic program_busy_flag_ff, write_latch_flag_ff, quad_lane_enable_ff;
  logic security_lock_bit_ff, guard_invert_ff, engine_start_ff;
  logic suspend_req_ff, resume_req_ff, quad_read_go_ff, cmd_reject_ff;
  logic [4:0] block_guard_bits_ff;
  int bad_count, total_checks;
  int n_start, n_rej, n_quad, n_sus, n_res;

  fsp_host_model i_host (.sys_clk(sys_clk), .cmd_strobe(cmd_strobe), .cmd_opcode(cmd_opcode),
    .cmd_wdata(cmd_wdata), .cmd_two_bytes(cmd_two_bytes));

  fsp_status_reg i_dut (.sys_clk(sys_clk), .rstn(rstn), .cmd_strobe(cmd_strobe),
    .cmd_opcode(cmd_opcode), .cmd_wdata(cmd_wdata), .cmd_two_bytes(cmd_two_bytes),
    .protect_pin(protect_pin), .engine_busy(engine_busy), .high_perf_mode(high_perf_mode),
    .nv_factory_init(nv_factory_init), .status_rdata_ff(status_rdata_ff),
    .program_busy_flag_ff(program_busy_flag_ff), .write_latch_flag_ff(write_latch_flag_ff),
    .quad_lane_enable_ff(quad_lane_enable_ff), .security_lock_bit_ff(security_lock_bit_ff),
    .block_guard_bits_ff(block_guard_bits_ff), .guard_invert_ff(guard_invert_ff),
    .engine_start_ff(engine_start_ff), .engine_opcode_ff(engine_opcode_ff),
    .suspend_req_ff(suspend_req_ff), .resume_req_ff(resume_req_ff),
    .quad_read_go_ff(quad_read_go_ff), .cmd_reject_ff(cmd_reject_ff));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Pulses stand one cycle between rising edges, so each is seen at one falling edge
  always @(negedge sys_clk) begin
    if (engine_start_ff === 1'b1) n_start++;
    if (cmd_reject_ff === 1'b1) n_rej++;
    if (quad_read_go_ff === 1'b1) n_quad++;
    if (suspend_req_ff === 1'b1) n_sus++;
    if (resume_req_ff === 1'b1) n_res++;
  end

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_cnt(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      bad_count++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_cnt

  // Issue one command; k names the single pulse expected (0 none, 1 start,
  // 2 reject, 3 quad go, 4 suspend, 5 resume), all others must stay quiet
  task automatic cmd(input logic [7:0] op, input logic [15:0] d, input logic two, input int k);
    int e[5];
    int g[5];
    e = '{n_start, n_rej, n_quad, n_sus, n_res};
    if (k > 0) e[k-1]++;
    i_host.send(op, d, two);
    repeat (3) @(negedge sys_clk);
    g = '{n_start, n_rej, n_quad, n_sus, n_res};
    for (int i = 0; i < 5; i++) chk_cnt(g[i], e[i]);
  endtask : cmd

  // Status write; an accepted one must hold busy for the whole cell time
  task automatic swr(input logic [15:0] d, input logic two, input logic ok,
                     input logic [15:0] exp);
    int n;
    n = 0;
    cmd(OP_STATUS_WRITE, d, two, ok ? 0 : 2);
    if (ok) begin
      chk_val({14'h0000, status_rdata_ff[1:0]}, 16'h0001);
      while (program_busy_flag_ff !== 1'b0 && n < 400) begin
        @(negedge sys_clk);
        n++;
      end
      chk_cnt(int'(n >= SRW_CYCLES_INT - 4 && n <= SRW_CYCLES_INT + 4), 1);
      repeat (2) @(negedge sys_clk);
    end
    chk_val(status_rdata_ff, exp);
    // Separate flag outputs other than busy must agree with the status image
    chk_val({1'b0, guard_invert_ff, 3'b000, security_lock_bit_ff, quad_lane_enable_ff, 2'b00,
             block_guard_bits_ff, write_latch_flag_ff, 1'b0}, exp & 16'h467e);
  endtask : swr

  // Power cycle; the factory clear is only needed once, at the very start
  task automatic power(input logic init);
    rstn = 1'b0;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    if (init) begin
      nv_factory_init = 1'b1;
      @(negedge sys_clk);
      nv_factory_init = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
  endtask : power

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run is well under two thousand cycles; this limit is far beyond it
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish;
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    protect_pin = 1'b0;
    engine_busy = 1'b0;
    high_perf_mode = 1'b0;
    nv_factory_init = 1'b0;
    @(negedge sys_clk);
    power(1'b1);
    chk_val(status_rdata_ff, 16'h0000);
    cmd(OP_QUAD_OUT_READ, 16'h0000, 1'b0, 2);
    cmd(OP_STATUS_WRITE, 16'h0004, 1'b1, 2);
    cmd(OP_PAGE_PROGRAM, 16'h0000, 1'b0, 2);
    cmd(OP_LATCH_SET, 16'h0000, 1'b0, 0);
    chk_val(status_rdata_ff, 16'h0002);
    cmd(OP_LATCH_CLEAR, 16'h0000, 1'b0, 0);
    chk_val(status_rdata_ff, 16'h0000);
    cmd(OP_LATCH_SET, 16'h0000, 1'b0, 0);
    cmd(OP_PAGE_PROGRAM, 16'h0000, 1'b0, 1);
    chk_val({8'h00, engine_opcode_ff}, 16'h0002);
    chk_val(status_rdata_ff, 16'h0000);
    // Engine running: busy, then suspend, resume and software reset
    engine_busy = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk_val(status_rdata_ff, 16'h0001);
    cmd(OP_SUSPEND, 16'h0000, 1'b0, 4);
    chk_val(status_rdata_ff, 16'h8001);
    cmd(OP_SUSPEND, 16'h0000, 1'b0, 0);
    cmd(OP_RESUME, 16'h0000, 1'b0, 5);
    chk_val(status_rdata_ff, 16'h0001);
    cmd(OP_SUSPEND, 16'h0000, 1'b0, 4);
    cmd(OP_LATCH_SET, 16'h0000, 1'b0, 0);
    cmd(OP_RESET_ENABLE, 16'h0000, 1'b0, 0);
    cmd(OP_RESET, 16'h0000, 1'b0, 0);
    chk_val(status_rdata_ff, 16'h0001);
    engine_busy = 1'b0;
    high_perf_mode = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk_val(status_rdata_ff, 16'h2000);
    high_perf_mode = 1'b0;
    repeat (3) @(negedge sys_clk);
    // Guard mode 00 with the pin low still takes writes; read-only bits ignore data
    cmd(OP_LATCH_SET, 16'h0000, 1'b0, 0);
    swr(16'hf854, 1'b1, 1'b1, 16'h4054);
    cmd(OP_LATCH_SET, 16'h0000, 1'b0, 0);
    cmd(OP_CHIP_ERASE_A, 16'h0000, 1'b0, 2);
    chk_val(status_rdata_ff, 16'h4056);
    swr(16'h401c, 1'b1, 1'b1, 16'h401c);
    cmd(OP_LATCH_SET, 16'h0000, 1'b0, 0);
    cmd(OP_CHIP_ERASE_B, 16'h0000, 1'b0, 1);
    chk_val({8'h00, engine_opcode_ff}, 16'h0060);
    // One byte write touches the low byte only
    cmd(OP_LATCH_SET, 16'h0000, 1'b0, 0);
    swr(16'hff80, 1'b0, 1'b1, 16'h4080);
    // Mode 01: pin low locks, pin high unlocks
    cmd(OP_LATCH_SET, 16'h0000, 1'b0, 0);
    swr(16'h0004, 1'b1, 1'b0, 16'h4082);
    protect_pin = 1'b1;
    repeat (4) @(negedge sys_clk);
    swr(16'h0700, 1'b1, 1'b1, 16'h0700);
    cmd(OP_QUAD_OUT_READ, 16'h0000, 1'b0, 3);
    cmd(OP_QUAD_IO_READ, 16'h0000, 1'b0, 3);
    cmd(OP_QUAD_WORD_READ, 16'h0000, 1'b0, 3);
    // Mode 10: locked until the next power cycle, which returns mode 00
    cmd(OP_LATCH_SET, 16'h0000, 1'b0, 0);
    swr(16'h0000, 1'b1, 1'b0, 16'h0702);
    power(1'b0);
    chk_val(status_rdata_ff, 16'h0600);
    // Lock bit cannot be cleared; mode 11 survives power cycles
    cmd(OP_LATCH_SET, 16'h0000, 1'b0, 0);
    swr(16'h0180, 1'b1, 1'b1, 16'h0580);
    cmd(OP_LATCH_SET, 16'h0000, 1'b0, 0);
    swr(16'h0000, 1'b1, 1'b0, 16'h0582);
    power(1'b0);
    cmd(OP_LATCH_SET, 16'h0000, 1'b0, 0);
    swr(16'h0000, 1'b1, 1'b0, 16'h0582);
    tally_and_finish;
  end
endmodule : tb
`default_nettype wire
